// [logic/gdl_top.sv]
// Gate driver lockout core with AHB-Lite register access
//
// Contract
// RULE1 - Standby or fault drives all gates low
// RULE2 - Shutdown locks high side until re-init
// RULE3 - Recovery low pulse may be 100 ns
// RULE4 - Recovery starts by clearing interrupt conditions
// RULE5 - Both enables high enter normal mode
// RULE6 - Low-side pulse enables high-side drivers
// RULE7 - High inputs low for deadtime plus 100 ns
// RULE8 - Simultaneous high inputs turn high sides on
// RULE9 - High toggle restores drive, FETs off
// RULE10 - Inputs edge sensitive; low rise re-arms
// RULE11 - Host puts high edge after low toggle
// RULE12 - Early high edge keeps gate locked out
// RULE13 - First low rise after both enables
// RULE14 - Wait 280 ns from enables to low
// RULE15 - Separate or joint phase inputs allowed
// RULE16 - Power-up: send both clear commands first
// RULE17 - Mask commands 0010/0011 mask sources; here only the 0010 bits gate faults
// RULE18 - Host sets deadtime zero or calibrated
// RULE19 - Lock bit rejects later mode commands
// RULE20 - Host pulses low then high sides
// RULE21 - Handler reads status, acts, then clears
// RULE22 - Answer returned in the following transfer
// RULE23 - Host waits 2.0 ms after reset release
// RULE24 - Per phase lock cleared by low rise
`timescale 1ns/1ps
`default_nettype none
module gdl_top (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Phase input pins
  input  wire logic [2:0]  phase_low_in,
  input  wire logic [2:0]  phase_high_in_n,
  // Enable pins
  input  wire logic        enable_one_pin,
  input  wire logic        enable_two_pin,
  // Fault detector pins, active high
  input  wire logic [3:0]  fault_in,
  // Gate drive outputs
  output logic      [2:0]  low_gate_out,
  output logic      [2:0]  high_gate_out
);
  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [gdl_pkg::SYNC_W-1:0] meta_q;  // First stage, read only by sync_q
  logic [gdl_pkg::SYNC_W-1:0] sync_q;  // Second stage, safe to use
  logic [gdl_pkg::SYNC_W-1:0] pins;    // Raw pin bundle

  assign pins = {fault_in, enable_two_pin, enable_one_pin,
                 phase_high_in_n, phase_low_in};

  // Two flops per pin, no logic between them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  logic [2:0] low_s;     // Synced low inputs
  logic [2:0] high_n_s;  // Synced high inputs
  logic       ens;       // Both enables high
  logic [3:0] fault_s;   // Synced fault levels

  assign low_s    = sync_q[2:0];
  assign high_n_s = sync_q[5:3];
  assign ens      = sync_q[6] & sync_q[7];
  assign fault_s  = sync_q[11:8];

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        acc;                 // Address phase taken
  logic        dwr_q, dwr_d;        // Write data phase pending
  logic        drd_q, drd_d;        // Read wait cycle pending
  logic [7:0]  dadr_q, dadr_d;      // Data phase address
  logic        rdy_q, rdy_d;        // Ready flop
  logic [31:0] rdat_q, rdat_d;      // Read data flop
  logic [31:0] rd_mux;              // Register read view
  logic        wr_cmd;              // Command write this cycle
  logic        wr_dead;             // Deadtime write this cycle
  logic [7:0]  cbyte;               // Written command byte

  assign acc     = hsel & htrans[1] & hready;
  assign wr_cmd  = dwr_q & (dadr_q == gdl_pkg::REG_CMD);
  assign wr_dead = dwr_q & (dadr_q == gdl_pkg::REG_DEAD);
  assign cbyte   = hwdata[7:0];

  // Reads take one wait cycle so that a read right after
  // a command write already sees the updated answer
  always_comb begin
    dwr_d  = acc & hwrite;
    drd_d  = acc & ~hwrite;
    dadr_d = acc ? haddr[7:0] : dadr_q;
    rdy_d  = ~(acc & ~hwrite);
    rdat_d = drd_q ? rd_mux : rdat_q;
  end

  // Register bus state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwr_q  <= 1'b0;
      drd_q  <= 1'b0;
      dadr_q <= 8'h00;
      rdy_q  <= 1'b1;
      rdat_q <= 32'h0000_0000;
    end else begin
      dwr_q  <= dwr_d;
      drd_q  <= drd_d;
      dadr_q <= dadr_d;
      rdy_q  <= rdy_d;
      rdat_q <= rdat_d;
    end
  end

  assign hrdata    = rdat_q;
  assign hreadyout = rdy_q;
  assign hresp     = 1'b0;  // Always OKAY; unmapped reads give zero

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  gdl_pkg::gdl_state_t st_q, st_d;   // Operating state
  logic [7:0] status_q, status_d;    // Sticky status
  logic [7:0] mask_q, mask_d;        // Mask, 1 hides a fault source; bits 7..4 gate nothing
  logic [3:0] mode_q, mode_d;        // Mode bits and lock
  logic [7:0] dead_q, dead_d;        // Deadtime cycles
  logic [7:0] pend_q, pend_d;        // Answer for the next transfer
  logic [7:0] resp_q, resp_d;        // Answer now readable
  logic [7:0] answer;                // Answer to this command
  logic [7:0] ev;                    // Status set events
  logic [7:0] clr;                   // Status clear strobes
  logic       refused;               // Locked mode change seen
  logic       fault_unm;             // Unmasked fault pending
  logic [2:0] early_v;               // Early edges per phase
  logic [2:0] locked_v;              // Lockout per phase
  logic [2:0] lo_g, hi_g;            // Gate copies

  assign fault_unm = |(status_q[3:0] & ~mask_q[3:0]);

  // Command decode and answer
  always_comb begin
    mask_d  = mask_q;
    mode_d  = mode_q;
    clr     = 8'h00;
    refused = 1'b0;
    if (wr_cmd) begin
      case (cbyte[7:4])
        gdl_pkg::NIB_MASK_LO: begin
          mask_d[3:0] = cbyte[3:0];  // RULE17
        end
        gdl_pkg::NIB_MASK_HI: begin
          mask_d[7:4] = cbyte[3:0];  // RULE17
        end
        gdl_pkg::NIB_MODE: begin
          if (mode_q[gdl_pkg::MODE_LOCK_BIT]) begin
            refused = 1'b1;  // RULE19
          end else begin
            mode_d = cbyte[3:0];
          end
        end
        default: begin
          if (cbyte == gdl_pkg::CMD_CLEAR_A) begin
            clr[3:0] = 4'hF;
          end
          if (cbyte == gdl_pkg::CMD_CLEAR_B) begin
            clr[7:4] = 4'hF;
          end
        end
      endcase
    end
    // Status reads answer status and mask, others the state and mode
    if (cbyte == gdl_pkg::CMD_READ_A) begin
      answer = status_q;
    end else if (cbyte == gdl_pkg::CMD_READ_B) begin
      answer = mask_q;
    end else begin
      answer = {1'b0, st_q, mode_q};
    end
    // Answer travels one transfer late
    pend_d = wr_cmd ? answer : pend_q;  // RULE22
    resp_d = wr_cmd ? pend_q : resp_q;  // RULE22
    dead_d = wr_dead ? hwdata[7:0] : dead_q;
  end

  // Status: a set in the clearing cycle wins
  always_comb begin
    ev[3:0]              = fault_s;
    ev[gdl_pkg::ST_REFUSED] = refused;
    ev[gdl_pkg::ST_EARLY]   = |early_v;
    ev[gdl_pkg::ST_STANDBY] = (st_q == gdl_pkg::GDL_NORMAL) & ~ens;
    ev[7]                = 1'b0;
    status_d = (status_q & ~clr) | ev;
  end

  // Operating state
  always_comb begin
    st_d = st_q;
    case (st_q)
      gdl_pkg::GDL_STANDBY: begin
        if (fault_unm) begin
          st_d = gdl_pkg::GDL_FAULT;
        end else if (ens) begin
          st_d = gdl_pkg::GDL_NORMAL;  // RULE5
        end
      end
      gdl_pkg::GDL_NORMAL: begin
        if (fault_unm) begin
          st_d = gdl_pkg::GDL_FAULT;  // RULE1
        end else if (!ens) begin
          st_d = gdl_pkg::GDL_STANDBY;  // RULE1
        end
      end
      gdl_pkg::GDL_FAULT: begin
        // Leave only once software cleared or masked the fault
        if (!fault_unm) begin
          st_d = gdl_pkg::GDL_STANDBY;
        end
      end
      default: begin
        st_d = gdl_pkg::GDL_STANDBY;
      end
    endcase
  end

  // Register the control state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= gdl_pkg::GDL_STANDBY;
      status_q <= gdl_pkg::STATUS_RST;
      mask_q   <= gdl_pkg::MASK_RST;
      mode_q   <= gdl_pkg::MODE_RST;
      dead_q   <= gdl_pkg::DEAD_RST;
      pend_q   <= gdl_pkg::RESP_RST;
      resp_q   <= gdl_pkg::RESP_RST;
    end else begin
      st_q     <= st_d;
      status_q <= status_d;
      mask_q   <= mask_d;
      mode_q   <= mode_d;
      dead_q   <= dead_d;
      pend_q   <= pend_d;
      resp_q   <= resp_d;
    end
  end

  // Register read view
  always_comb begin
    case (dadr_q)
      gdl_pkg::REG_CMD:  rd_mux = {24'h00_0000, resp_q};
      gdl_pkg::REG_DEAD: rd_mux = {24'h00_0000, dead_q};
      gdl_pkg::REG_STAT: rd_mux = {9'h000, mode_q[gdl_pkg::MODE_LOCK_BIT],
                                   hi_g, lo_g, locked_v, sync_q[7:6],
                                   st_q, status_q};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Phase units
  // ----------------------------------------------------------------
  gdl_phase_if ph_if [3] ();

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      assign ph_if[g].normal    = (st_q == gdl_pkg::GDL_NORMAL);  // RULE1
      assign ph_if[g].dead      = dead_q;
      assign ph_if[g].low_in    = low_s[g];
      assign ph_if[g].high_in_n = high_n_s[g];
      assign lo_g[g]            = ph_if[g].low_gate;
      assign hi_g[g]            = ph_if[g].high_gate;
      assign locked_v[g]        = ph_if[g].locked;
      assign early_v[g]         = ph_if[g].early;
      gdl_phase u_phase (
        .hclk    (hclk),
        .hresetn (hresetn),
        .bus     (ph_if[g])
      );
    end
  endgenerate

  assign low_gate_out  = lo_g;
  assign high_gate_out = hi_g;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_off_outside_normal;
    st_q != gdl_pkg::GDL_NORMAL |=> low_gate_out == 3'h0 && high_gate_out == 3'h0;
  endproperty
  a_off_outside_normal: assert property (p_off_outside_normal) else $error("gate on outside normal");  // RULE1

  property p_fault_stop;
    fault_unm |=> st_q == gdl_pkg::GDL_FAULT;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop drive");  // RULE1

  property p_enter_normal;
    st_q == gdl_pkg::GDL_STANDBY && ens && !fault_unm |=> st_q == gdl_pkg::GDL_NORMAL;
  endproperty
  a_enter_normal: assert property (p_enter_normal) else $error("enables did not give normal");  // RULE5

  property p_mask;
    wr_cmd && cbyte[7:4] == gdl_pkg::NIB_MASK_LO |=> mask_q[3:0] == $past(cbyte[3:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not taken");  // RULE17

  property p_lock_reject;
    wr_cmd && cbyte[7:4] == gdl_pkg::NIB_MODE && mode_q[gdl_pkg::MODE_LOCK_BIT]
      |=> $stable(mode_q) && status_q[gdl_pkg::ST_REFUSED];
  endproperty
  a_lock_reject: assert property (p_lock_reject) else $error("locked mode changed");  // RULE19

  property p_late_answer;
    wr_cmd && cbyte == gdl_pkg::CMD_READ_A |=> pend_q == $past(status_q) && resp_q == $past(pend_q);
  endproperty
  a_late_answer: assert property (p_late_answer) else $error("answer not one transfer late");  // RULE22

  property p_resp_hold;
    !wr_cmd |=> $stable(resp_q);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("answer moved without command");  // RULE22

  property p_read_wait;
    acc && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait cycle wrong");

  c_fault: cover property (st_q == gdl_pkg::GDL_FAULT ##1 st_q == gdl_pkg::GDL_STANDBY);
  c_refuse: cover property (refused);
  c_normal_hi: cover property (st_q == gdl_pkg::GDL_NORMAL && high_gate_out == 3'h7);
  c_read: cover property (drd_q && dadr_q == gdl_pkg::REG_CMD);
endmodule : gdl_top
`default_nettype wire

// [logic/gdl_pkg.sv]
// Shared constants and types of the gate driver lockout block
package gdl_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD  = 8'h00;  // Command write, delayed answer read
  localparam logic [7:0] REG_DEAD = 8'h04;  // Deadtime in clock cycles
  localparam logic [7:0] REG_STAT = 8'h08;  // Live state, read only

  // ----------------------------------------------------------------
  // Command encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] NIB_MASK_LO = 4'h2;   // 0010 xxxx: mask bits 3..0
  localparam logic [3:0] NIB_MASK_HI = 4'h3;   // 0011 xxxx: mask bits 7..4
  localparam logic [3:0] NIB_MODE    = 4'h4;   // 0100 xxxx: mode, bit 0 locks
  localparam logic [7:0] CMD_READ_A  = 8'h00;  // status_read_cmd_a
  localparam logic [7:0] CMD_READ_B  = 8'h01;  // status_read_cmd_b
  localparam logic [7:0] CMD_CLEAR_A = 8'h60;  // clear_irq_cmd_a
  localparam logic [7:0] CMD_CLEAR_B = 8'h61;  // clear_irq_cmd_b

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_LOCK_BIT = 0;  // Lock bit inside the mode nibble
  localparam int ST_REFUSED    = 4;  // Mode change refused
  localparam int ST_EARLY      = 5;  // High edge came before re-arm
  localparam int ST_STANDBY    = 6;  // Enables dropped in normal mode
  localparam int SYNC_W        = 12; // Pins passing the synchroniser

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] DEAD_RST   = 8'h00;
  localparam logic [3:0] MODE_RST   = 4'h0;
  localparam logic [7:0] RESP_RST   = 8'h00;

  // Device operating state, one-hot
  typedef enum logic [2:0] {
    GDL_STANDBY = 3'b001,
    GDL_NORMAL  = 3'b010,
    GDL_FAULT   = 3'b100
  } gdl_state_t;
endpackage : gdl_pkg

// [logic/gdl_phase_if.sv]
// Carrier between the control core and one phase unit
`timescale 1ns/1ps
`default_nettype none
interface gdl_phase_if;
  logic       normal;     // Device in normal mode
  logic [7:0] dead;       // Deadtime in cycles
  logic       low_in;     // Synchronised low-side input
  logic       high_in_n;  // Synchronised high-side input, active low
  logic       low_gate;   // Low gate drive
  logic       high_gate;  // High gate drive
  logic       locked;     // High side locked out
  logic       early;      // High edge seen while locked

  modport ctl (output normal, dead, low_in, high_in_n,
               input  low_gate, high_gate, locked, early);
  modport ph  (input  normal, dead, low_in, high_in_n,
               output low_gate, high_gate, locked, early);
endinterface : gdl_phase_if
`default_nettype wire

// [logic/gdl_phase.sv]
// One phase: high-side lockout, re-arm by edges, deadtime interlock
`timescale 1ns/1ps
`default_nettype none
module gdl_phase (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link to control core
  gdl_phase_if.ph  bus
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       lock_q, lock_d;      // Locked until low-side rise
  logic       arm_q, arm_d;        // Re-armed, waiting high toggle
  logic       lo_q, lo_d;          // Low gate flop
  logic       hi_q, hi_d;          // High gate flop
  logic       plo_q, plo_d;        // Previous low input
  logic       phn_q, phn_d;        // Previous high input
  logic [7:0] cnt_q, cnt_d;        // Deadtime counter
  logic       lo_rise, hn_edge, hn_fall;
  logic       want_lo, want_hi, pend_on, other_on;

  // Edge detection on already synchronised inputs
  assign lo_rise = bus.low_in & ~plo_q;
  assign hn_edge = bus.high_in_n ^ phn_q;
  assign hn_fall = ~bus.high_in_n & phn_q;
  // Joint input drives both pins alike; conflict gives both off
  assign want_lo = bus.low_in & bus.high_in_n;
  assign want_hi = ~bus.high_in_n & ~bus.low_in & ~lock_q & ~arm_q;
  assign pend_on  = (want_lo & ~lo_q) | (want_hi & ~hi_q);
  assign other_on = (want_lo & hi_q) | (want_hi & lo_q);

  // Next state of the phase
  always_comb begin
    lock_d = lock_q;
    arm_d  = arm_q;
    lo_d   = lo_q;
    hi_d   = hi_q;
    cnt_d  = 8'h00;
    plo_d  = bus.low_in;
    phn_d  = bus.high_in_n;
    if (!bus.normal) begin
      // Standby or fault: all gates off, high side locked
      lo_d   = 1'b0;  // RULE1
      hi_d   = 1'b0;  // RULE1
      lock_d = 1'b1;  // RULE2
      arm_d  = 1'b0;
    end else begin
      // Only a low-side rise in normal mode re-arms
      if (lock_q && lo_rise) begin
        lock_d = 1'b0;  // RULE6 RULE10 RULE24
        arm_d  = 1'b1;
      end
      // High toggle after re-arm restores drive
      if (arm_q && hn_fall) begin
        arm_d = 1'b0;  // RULE9
      end
      // Turn-off is immediate
      if (!want_lo) begin
        lo_d = 1'b0;
      end
      if (!want_hi) begin
        hi_d = 1'b0;
      end
      // Turn-on waits for deadtime with both gates off
      if (pend_on && !other_on) begin
        if (cnt_q >= bus.dead) begin
          lo_d = want_lo;
          hi_d = want_hi;  // RULE8
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
    end
  end

  // Register the phase state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 1'b1;
      arm_q  <= 1'b0;
      lo_q   <= 1'b0;
      hi_q   <= 1'b0;
      plo_q  <= 1'b0;
      phn_q  <= 1'b1;
      cnt_q  <= 8'h00;
    end else begin
      lock_q <= lock_d;
      arm_q  <= arm_d;
      lo_q   <= lo_d;
      hi_q   <= hi_d;
      plo_q  <= plo_d;
      phn_q  <= phn_d;
      cnt_q  <= cnt_d;
    end
  end

  // Outputs toward the core
  assign bus.low_gate  = lo_q;
  assign bus.high_gate = hi_q;
  assign bus.locked    = lock_q | arm_q;
  assign bus.early     = bus.normal & lock_q & hn_edge & ~lo_rise;  // RULE12

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_lock_on_exit;
    @(posedge hclk) disable iff (!hresetn)
    !bus.normal |=> lock_q && !lo_q && !hi_q;
  endproperty
  a_lock_on_exit: assert property (p_lock_on_exit) else $error("phase not locked off");  // RULE2

  property p_early_stays;
    @(posedge hclk) disable iff (!hresetn)
    bus.normal && lock_q && hn_edge && !lo_rise |=> lock_q;
  endproperty
  a_early_stays: assert property (p_early_stays) else $error("early high edge unlocked");  // RULE12

  property p_rearm;
    @(posedge hclk) disable iff (!hresetn)
    bus.normal && lock_q && lo_rise |=> !lock_q && arm_q;
  endproperty
  a_rearm: assert property (p_rearm) else $error("low rise did not re-arm");  // RULE24

  property p_hi_gated;
    @(posedge hclk) disable iff (!hresetn)
    (lock_q || arm_q) |-> !hi_q;
  endproperty
  a_hi_gated: assert property (p_hi_gated) else $error("high gate on while locked");  // RULE12

  property p_restore;
    @(posedge hclk) disable iff (!hresetn)
    bus.normal && arm_q && hn_fall |=> !arm_q && !lock_q;
  endproperty
  a_restore: assert property (p_restore) else $error("high toggle did not restore");  // RULE9

  property p_no_overlap;
    @(posedge hclk) disable iff (!hresetn)
    !(lo_q && hi_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates on");  // RULE8

  c_restored: cover property (@(posedge hclk) disable iff (!hresetn) arm_q ##1 !arm_q && !lock_q);
endmodule : gdl_phase
`default_nettype wire

// [sim/gdl_host_model.sv]
// Host controller model driving the phase and enable pins
`timescale 1ns/1ps
`default_nettype none
module gdl_host_model (
  // Clock
  input  wire logic       hclk,
  // Pins toward the device
  output var  logic [2:0] phase_low_in,
  output var  logic [2:0] phase_high_in_n,
  output var  logic       enable_one_pin,
  output var  logic       enable_two_pin
);
  // ----------------------------------------------------------------
  // Idle pins: high sides commanded off, enables low
  // ----------------------------------------------------------------
  initial begin
    phase_low_in    = 3'h0;
    phase_high_in_n = 3'h7;
    enable_one_pin  = 1'b0;
    enable_two_pin  = 1'b0;
  end

  // Both enables up, then hold off the first low edge
  task automatic enable_up(input int gap);
    enable_one_pin <= 1'b1;
    enable_two_pin <= 1'b1;
    repeat (gap) @(posedge hclk);
  endtask : enable_up

  // Each enable on its own; one alone must not give normal mode
  task automatic enable_set(input logic [1:0] e, input int gap);
    enable_one_pin <= e[0];
    enable_two_pin <= e[1];
    repeat (gap) @(posedge hclk);
  endtask : enable_set

  // Low-side pulse of len cycles; a short one suits recovery
  task automatic lows(input logic [2:0] m, input int len);
    phase_low_in <= m;
    repeat (len) @(posedge hclk);
    phase_low_in <= 3'h0;
    repeat (8) @(posedge hclk);
  endtask : lows

  // High-side command; all phases together avoids motor current
  task automatic highs(input logic [2:0] v);
    phase_high_in_n <= v;
    repeat (12) @(posedge hclk);
  endtask : highs
endmodule : gdl_host_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench of the gate driver lockout block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  fault_in;
  logic [2:0]  lo_in, hi_in_n, low_gate_out, high_gate_out;
  logic        en1, en2;
  int          n_mismatch, samples_checked;
  // Command rows: upper byte is the answer expected, zero means none
  localparam logic [15:0] ROWS [10] = '{16'h0060, 16'h0061, 16'h0025, 16'h0036, 16'h0001,
                                        16'h6500, 16'h0041, 16'h0042, 16'h0000, 16'h1000};

  always #4 hclk = ~hclk;

  gdl_top gdl_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phase_low_in(lo_in),
    .phase_high_in_n(hi_in_n), .enable_one_pin(en1), .enable_two_pin(en2),
    .fault_in(fault_in), .low_gate_out(low_gate_out), .high_gate_out(high_gate_out));

  gdl_host_model gdl_host_model_inst (.hclk(hclk), .phase_low_in(lo_in),
    .phase_high_in_n(hi_in_n), .enable_one_pin(en1), .enable_two_pin(en2));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One AHB single transfer; waits on hready, no fixed latency
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  // Verdict
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    fault_in = 0; n_mismatch = 0; samples_checked = 0; hsize = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Standby after reset: gates off, all phases locked
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk(rdv, 32'h0000E100);
    // Command rows; each answer shows one command later
    for (int i = 0; i < 10; i++) begin
      ahb(1'b1, gdl_pkg::REG_CMD, {24'h0, ROWS[i][7:0]});
      if (ROWS[i][15:8] != 8'h00) begin
        ahb(1'b0, gdl_pkg::REG_CMD, 32'h0);
        chk(rdv, {24'h0, ROWS[i][15:8]});
      end
    end
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk({31'h0, rdv[22]}, 32'h1);
    ahb(1'b1, gdl_pkg::REG_DEAD, 32'h3);
    ahb(1'b0, gdl_pkg::REG_DEAD, 32'h0);
    chk(rdv, 32'h3);
    $display("registers done");
    // Recovery: enables, low pulse, joint high toggle
    gdl_host_model_inst.enable_up(36);
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk({29'h0, rdv[10:8]}, 32'h2);
    gdl_host_model_inst.lows(3'h7, 13);
    gdl_host_model_inst.highs(3'h0);
    chk({29'h0, high_gate_out}, 32'h7);
    gdl_host_model_inst.highs(3'h7);
    chk({26'h0, high_gate_out, low_gate_out}, 32'h0);
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk({29'h0, rdv[15:13]}, 32'h0);
    gdl_host_model_inst.highs(3'h6);
    chk({29'h0, high_gate_out}, 32'h1);
    gdl_host_model_inst.highs(3'h7);
    $display("recovery done");
    // Masked fault keeps normal mode; unmasked one shuts down
    fault_in <= 4'h1;
    repeat (8) @(posedge hclk);
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk({29'h0, rdv[10:8]}, 32'h2);
    fault_in <= 4'h2;
    repeat (8) @(posedge hclk);
    chk({26'h0, high_gate_out, low_gate_out}, 32'h0);
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk({26'h0, rdv[15:13], rdv[10:8]}, 32'h3C);
    // Handler: both status reads, answer one command late
    ahb(1'b1, gdl_pkg::REG_CMD, {24'h0, gdl_pkg::CMD_READ_A});
    ahb(1'b1, gdl_pkg::REG_CMD, {24'h0, gdl_pkg::CMD_READ_B});
    ahb(1'b0, gdl_pkg::REG_CMD, 32'h0);
    chk(rdv, 32'h13);
    fault_in <= 4'h0;
    // Let the pin pass the synchroniser, else set wins over clear
    repeat (4) @(posedge hclk);
    ahb(1'b1, gdl_pkg::REG_CMD, 32'h60);
    // High edge before the low toggle stays locked out
    gdl_host_model_inst.highs(3'h0);
    chk({29'h0, high_gate_out}, 32'h0);
    gdl_host_model_inst.highs(3'h7);
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk({31'h0, rdv[5]}, 32'h1);
    gdl_host_model_inst.lows(3'h7, 13);
    gdl_host_model_inst.highs(3'h0);
    chk({29'h0, high_gate_out}, 32'h7);
    gdl_host_model_inst.highs(3'h7);
    $display("fault done");
    // One enable dropped: standby, gates off, phases locked
    gdl_host_model_inst.enable_set(2'b10, 8);
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk({24'h0, rdv[15:8]}, 32'hF1);
    chk({31'h0, rdv[6]}, 32'h1);
    $display("enable drop done");
    // Reset in mid-run: back to standby, locked, lock bit gone
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, gdl_pkg::REG_STAT, 32'h0);
    chk(rdv, 32'h0000F100);
    $display("reset done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
